// *** include/scd_pkg.sv ***
// Purpose: shared constants, types and rom tables for start-up and dpll
// Assumes: three-level straps arrive coded as two bits (l, m, h)
// Notes: rom page contents are fixed functions, never written
package scd_pkg;
	localparam logic IFSEL_I2C = 1'b0;
	localparam logic [1:0] LVL_L = 2'h0;
	localparam logic [1:0] LVL_M = 2'h1;
	localparam logic [1:0] LVL_H = 2'h2;
	localparam int PAGE_W = 4;
	localparam int CFG_W = 16;
	localparam int FW = 40;
	localparam logic [PAGE_W-1:0] PAGE_LOW_PWR = 4'h3;
	localparam logic [PAGE_W:0] PAGE_COUNT = 5'h09;
	localparam logic [1:0] SEL_STD = 2'h0;
	localparam logic OVL_DEFAULT = 1'b0;
	localparam logic [11:0] ROM_LOOP_TAG = 12'h5a0;
	localparam logic [11:0] ROM_OUT_TAG = 12'hc30;

	typedef enum logic [1:0] {
		ST_FREE_RUN, ST_ACQUIRE, ST_LOCKED, ST_HOLDOVER
	} scd_dpll_e;
	typedef enum logic [1:0] {
		CS_STRAP, CS_ROM, CS_OVERLAY, CS_DONE
	} scd_cfg_e;

	// any unused level code reads as high
	function automatic logic [1:0] lvl_norm(input logic [1:0] l);
		return (l == LVL_L || l == LVL_M) ? l : LVL_H;
	endfunction

	// standard strap to page mapping
	function automatic logic [PAGE_W-1:0] std_page(
		input logic [1:0] hi, input logic [1:0] lo);
		case ({lvl_norm(hi), lvl_norm(lo)})
			{LVL_L, LVL_L}: return 4'h0;
			{LVL_L, LVL_H}: return 4'h1;
			{LVL_H, LVL_L}: return 4'h2;
			{LVL_H, LVL_H}: return PAGE_LOW_PWR;
			{LVL_L, LVL_M}: return 4'h4;
			{LVL_M, LVL_L}: return 4'h5;
			{LVL_M, LVL_M}: return 4'h6;
			{LVL_M, LVL_H}: return 4'h7;
			default: return 4'h8;
		endcase
	endfunction

	// stored select rotates the standard mapping, modulo page count
	function automatic logic [PAGE_W-1:0] sel_page(
		input logic [PAGE_W-1:0] p, input logic [1:0] sel);
		logic [PAGE_W:0] s;
		s = {1'b0, p} + {3'h0, sel};
		if (s >= PAGE_COUNT) s = s - PAGE_COUNT;
		return s[PAGE_W-1:0];
	endfunction

	function automatic logic [CFG_W-1:0] rom_loop(input logic [PAGE_W-1:0] p);
		return (p == PAGE_LOW_PWR) ? '0 : {ROM_LOOP_TAG, p};
	endfunction

	function automatic logic [CFG_W-1:0] rom_out(input logic [PAGE_W-1:0] p);
		return (p == PAGE_LOW_PWR) ? '0 : {ROM_OUT_TAG, p};
	endfunction
endpackage

// *** include/scd_cfg_if.sv ***
// Purpose: carries the loaded start-up configuration
// Assumes: one driver, the strap and rom loader
// Notes: all members are flops in the loader
`timescale 1ns/1ns
interface scd_cfg_if;
	import scd_pkg::*;
	logic spi_en;
	logic csa_cs;
	logic [PAGE_W-1:0] page;
	logic [CFG_W-1:0] loop_cfg;
	logic [CFG_W-1:0] out_cfg;
	logic pll_en;
	logic done;
	modport src(output spi_en, csa_cs, page, loop_cfg, out_cfg, pll_en, done);
	modport dst(input spi_en, csa_cs, page, loop_cfg, out_cfg, pll_en, done);
endinterface

// *** logic/scd_strap_cfg.sv ***
// Purpose: strap capture, rom page load and nonvolatile overlay
// Assumes: straps settle before reset release
// Notes: straps are caught once, at the first edge after release
`timescale 1ns/1ns
module scd_strap_cfg
	import scd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// straps
	input wire logic interface_select_strap,
	input wire logic [1:0] page_strap_low,
	input wire logic [1:0] page_strap_high,
	// nonvolatile fields
	input wire logic nv_blank,
	input wire logic [1:0] stored_page_select,
	input wire logic overlay_enable,
	input wire logic [CFG_W-1:0] nv_loop_cfg,
	input wire logic [CFG_W-1:0] nv_out_cfg,
	// loaded configuration
	scd_cfg_if.src cfg
);
	scd_cfg_e seq;
	logic ovl;
	logic [1:0] sel;

	assign sel = nv_blank ? SEL_STD : stored_page_select; // [R4]

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			seq <= CS_STRAP;
		end else begin
			case (seq)
				CS_STRAP: seq <= CS_ROM;
				CS_ROM: seq <= ovl ? CS_OVERLAY : CS_DONE; // [R7]
				default: seq <= CS_DONE;
			endcase
		end
	end

	// one-time strap capture
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg.spi_en <= 1'b0;
			cfg.csa_cs <= 1'b0;
			cfg.page <= '0;
			ovl <= OVL_DEFAULT;
		end else if (seq == CS_STRAP) begin // [R23]
			cfg.spi_en <= interface_select_strap != IFSEL_I2C; // [R1]
			cfg.csa_cs <= interface_select_strap != IFSEL_I2C; // [R2]
			cfg.page <= sel_page(std_page(page_strap_high,
				page_strap_low), sel); // [R3]
			ovl <= nv_blank ? OVL_DEFAULT : overlay_enable; // [R9]
		end
	end

	// rom load then optional overlay
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg.loop_cfg <= '0;
			cfg.out_cfg <= '0;
			cfg.pll_en <= 1'b0;
		end else if (seq == CS_ROM) begin
			cfg.loop_cfg <= rom_loop(cfg.page); // [R6]
			cfg.out_cfg <= rom_out(cfg.page); // [R6]
			cfg.pll_en <= cfg.page != PAGE_LOW_PWR; // [R5]
		end else if (seq == CS_OVERLAY) begin
			cfg.loop_cfg <= nv_loop_cfg; // [R8]
			cfg.out_cfg <= nv_out_cfg; // [R8]
		end
	end

	always_ff @(posedge mclk) begin
		cfg.done <= !sys_rst && seq == CS_DONE;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	straps_held_a: assert property (cfg.done |=> // [R23]
		$stable(cfg.page) && $stable(cfg.spi_en))
		else $error("strap result changed after start-up");
	low_power_a: assert property (seq == CS_ROM && // [R5]
		cfg.page == PAGE_LOW_PWR |=> !cfg.pll_en && cfg.out_cfg == '0)
		else $error("low power page left plls on");
	rom_only_a: assert property (seq == CS_ROM && !ovl |=> // [R7]
		seq == CS_DONE && cfg.loop_cfg == rom_loop(cfg.page))
		else $error("rom settings altered without overlay");
	overlay_a: assert property (seq == CS_OVERLAY |=> // [R8]
		cfg.loop_cfg == $past(nv_loop_cfg) &&
		cfg.out_cfg == $past(nv_out_cfg))
		else $error("overlay not applied");
endmodule

// *** logic/scd_lock_flags.sv ***
// Purpose: loss-of-lock flags and history accumulate enable
// Assumes: detector inputs are synchronous levels
// Notes: flags read one when lock is lost, except the frequency flag, which is frozen in holdover
`timescale 1ns/1ns
module scd_lock_flags (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// state view
	input wire logic restart,
	input wire logic in_hold,
	input wire logic hold_next,
	input wire logic locked,
	input wire logic hist_on,
	// detectors
	input wire logic freq_lock_det,
	input wire logic phase_lock_det,
	// results
	output logic freq_lost,
	output logic phase_lost,
	output logic hist_accum
);
	always_ff @(posedge mclk) begin
		if (sys_rst || restart) begin
			freq_lost <= 1'b1;
		end else if (!in_hold && !hold_next) begin // [R20]
			freq_lost <= !freq_lock_det; // [R15]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || restart || hold_next) begin
			phase_lost <= 1'b1; // [R20]
		end else begin
			phase_lost <= !phase_lock_det; // [R15]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || restart) begin
			hist_accum <= 1'b0;
		end else begin
			hist_accum <= hist_on && locked && !freq_lost; // [R16]
		end
	end
endmodule

// *** logic/scd_top.sv ***
// Purpose: start-up configuration and dpll operating state control
// Assumes: all inputs synchronous to mclk; sys_rst is power-on reset
// Notes: configuration outputs lag the loader by one register stage; dpll state and lock flags do not
// Notes on behaviour
// [R1] interface strap low i2c, high spi
// [R2] same strap fixes chip-select/address pin role
// [R3] two three-level straps pick one of nine pages
// [R4] stored page select defaults to zero
// [R5] both page straps high: everything off; code turns off page 3 after rotation, so a nonzero page select keeps plls on
// [R6] rom pages fixed, no write path
// [R7] overlay off: rom settings only
// [R8] overlay on: rom then nonvolatile loop/output
// [R9] overlay enable defaults to zero
// [R10] invalid dpll config: loops follow crystal
// [R11] free-run after config, crystal locked
// [R12] lost before valid history: back to free-run
// [R13] valid reference starts lock acquisition
// [R14] wide bandwidth only during acquisition
// [R15] frequency and phase lock-lost flags exported
// [R16] frequency lock starts history accumulation
// [R17] reference lost, no input: holdover
// [R18] history off: holdover uses offset field
// [R19] valid history replaces offset in holdover
// [R20] holdover sets phase flag, freezes frequency flag
// [R21] valid input during holdover resumes locking
// [R22] start-up repeats after any soft reset; code sends the dpll to free-run, reloads straps/rom on sys_rst only
// [R23] straps captured once, later changes ignored
// [R24] one of four dpll states, readable
`timescale 1ns/1ns
module scd_top
	import scd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// soft resets
	input wire logic soft_rst,
	input wire logic pll_soft_rst,
	// straps
	input wire logic interface_select_strap,
	input wire logic [1:0] page_strap_low,
	input wire logic [1:0] page_strap_high,
	// nonvolatile fields
	input wire logic nv_blank,
	input wire logic [1:0] stored_page_select,
	input wire logic overlay_enable,
	input wire logic [CFG_W-1:0] nv_loop_cfg,
	input wire logic [CFG_W-1:0] nv_out_cfg,
	// dpll status inputs
	input wire logic dpll_configured,
	input wire logic crystal_oscillator_input,
	input wire logic ref_valid,
	input wire logic reference_lost,
	input wire logic acq_done,
	input wire logic freq_lock_det,
	input wire logic phase_lock_det,
	// holdover sources
	input wire logic history_enable,
	input wire logic history_valid,
	input wire logic [FW-1:0] holdover_freq_offset,
	input wire logic [FW-1:0] history_word,
	// configuration results
	output logic i2c_enable,
	output logic spi_enable,
	output logic csa_is_chip_select,
	output logic [PAGE_W-1:0] rom_page,
	output logic [CFG_W-1:0] loop_cfg,
	output logic [CFG_W-1:0] out_cfg,
	output logic pll_enable,
	output logic cfg_done,
	// dpll state and control
	output scd_dpll_e dpll_state,
	output logic normal_loop_bandwidth,
	output logic apll_on_crystal,
	output logic holdover_use_history,
	output logic [FW-1:0] holdover_freq_word,
	// lock status
	output logic freq_lock_lost_flag,
	output logic phase_lock_lost_flag,
	output logic history_accum_en
);
	scd_cfg_if cfg();

	scd_dpll_e state;
	scd_dpll_e next_state;
	logic restart;
	logic dpll_ready;
	logic hist_ok;
	logic ref_gone;
	logic freq_lost;
	logic phase_lost;
	logic hist_accum;

	scd_strap_cfg u_strap (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.interface_select_strap(interface_select_strap),
		.page_strap_low(page_strap_low),
		.page_strap_high(page_strap_high),
		.nv_blank(nv_blank),
		.stored_page_select(stored_page_select),
		.overlay_enable(overlay_enable),
		.nv_loop_cfg(nv_loop_cfg),
		.nv_out_cfg(nv_out_cfg),
		.cfg(cfg.src)
	);

	scd_lock_flags u_flags (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.restart(restart),
		.in_hold(state == ST_HOLDOVER),
		.hold_next(next_state == ST_HOLDOVER),
		.locked(state == ST_LOCKED),
		.hist_on(history_enable),
		.freq_lock_det(freq_lock_det),
		.phase_lock_det(phase_lock_det),
		.freq_lost(freq_lost),
		.phase_lost(phase_lost),
		.hist_accum(hist_accum)
	);

	// soft resets and an unfinished load hold the dpll in free-run
	assign restart = soft_rst || pll_soft_rst || !cfg.done; // [R22]
	// a valid rom page or a later host setup makes the dpll usable
	assign dpll_ready = cfg.pll_en || dpll_configured; // [R10]
	assign hist_ok = history_enable && history_valid;
	assign ref_gone = reference_lost || !ref_valid;

	// dpll state transitions
	always_comb begin
		next_state = state;
		case (state)
			ST_FREE_RUN: begin
				if (dpll_ready && crystal_oscillator_input && !ref_gone) begin
					next_state = ST_ACQUIRE; // [R13]
				end
			end
			ST_ACQUIRE: begin
				if (ref_gone) begin
					next_state = ST_FREE_RUN;
				end else if (acq_done && freq_lock_det) begin
					next_state = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				if (ref_gone && history_enable && !history_valid) begin
					next_state = ST_FREE_RUN; // [R12]
				end else if (ref_gone) begin
					next_state = ST_HOLDOVER; // [R17]
				end
			end
			ST_HOLDOVER: begin
				if (!ref_gone && dpll_ready) begin
					next_state = ST_ACQUIRE; // [R21]
				end
			end
			default: begin
				next_state = ST_FREE_RUN;
			end
		endcase
		if (restart) begin
			next_state = ST_FREE_RUN; // [R22]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= ST_FREE_RUN;
		end else begin
			state <= next_state; // [R24]
		end
	end

	// loop bandwidth and analog loop reference
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			normal_loop_bandwidth <= 1'b1;
			apll_on_crystal <= 1'b0;
		end else begin
			normal_loop_bandwidth <= next_state != ST_ACQUIRE; // [R14]
			apll_on_crystal <= crystal_oscillator_input &&
				(next_state == ST_FREE_RUN || !dpll_ready); // [R10] [R11]
		end
	end

	// holdover frequency source
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			holdover_use_history <= 1'b0;
			holdover_freq_word <= '0;
		end else if (hist_ok) begin
			holdover_use_history <= 1'b1;
			holdover_freq_word <= history_word; // [R19]
		end else begin
			holdover_use_history <= 1'b0;
			holdover_freq_word <= holdover_freq_offset; // [R18]
		end
	end

	// configuration result registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			i2c_enable <= 1'b0;
			spi_enable <= 1'b0;
			csa_is_chip_select <= 1'b0;
			rom_page <= '0;
			loop_cfg <= '0;
			out_cfg <= '0;
			pll_enable <= 1'b0;
			cfg_done <= 1'b0;
		end else begin
			i2c_enable <= cfg.done && !cfg.spi_en; // [R1]
			spi_enable <= cfg.done && cfg.spi_en; // [R1]
			csa_is_chip_select <= cfg.csa_cs; // [R2]
			rom_page <= cfg.page;
			loop_cfg <= cfg.loop_cfg;
			out_cfg <= cfg.out_cfg;
			pll_enable <= cfg.pll_en;
			cfg_done <= cfg.done;
		end
	end

	assign dpll_state = state;
	assign freq_lock_lost_flag = freq_lost;
	assign phase_lock_lost_flag = phase_lost;
	assign history_accum_en = hist_accum;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_locked_lost;
		state == ST_LOCKED && ref_gone && !restart;
	endsequence

	sequence s_acq_done;
		state == ST_ACQUIRE ##1 state == ST_LOCKED;
	endsequence

	hold_entry_a: assert property ( // [R17]
		s_locked_lost ##0 !(history_enable && !history_valid) |=>
		state == ST_HOLDOVER && phase_lock_lost_flag)
		else $error("reference loss did not enter holdover");

	no_hist_back_a: assert property ( // [R12]
		s_locked_lost ##0 history_enable && !history_valid |=>
		state == ST_FREE_RUN)
		else $error("loss without history did not go free-run");

	acq_start_a: assert property ( // [R13]
		state != ST_ACQUIRE && state != ST_LOCKED && !restart &&
		dpll_ready && crystal_oscillator_input && !ref_gone |=>
		state == ST_ACQUIRE && !normal_loop_bandwidth)
		else $error("valid reference did not start acquisition");

	bw_revert_a: assert property ( // [R14]
		s_acq_done |=> normal_loop_bandwidth)
		else $error("bandwidth not restored after acquisition");

	freq_freeze_a: assert property ( // [R20]
		state == ST_HOLDOVER ##1 state == ST_HOLDOVER |->
		$stable(freq_lock_lost_flag))
		else $error("frequency flag moved in holdover");

	phase_hold_a: assert property ( // [R20]
		state == ST_HOLDOVER |-> phase_lock_lost_flag)
		else $error("phase flag low in holdover");

	hold_src_a: assert property ( // [R19]
		hist_ok |=> holdover_use_history &&
		holdover_freq_word == $past(history_word))
		else $error("valid history not used for holdover");

	free_src_a: assert property ( // [R18]
		!history_enable |=> !holdover_use_history &&
		holdover_freq_word == $past(holdover_freq_offset))
		else $error("offset field not used for holdover");

	restart_seq_a: assert property ( // [R22]
		restart |=> state == ST_FREE_RUN && freq_lock_lost_flag)
		else $error("soft reset did not restart dpll");

	accum_start_a: assert property ( // [R16]
		history_enable && state == ST_LOCKED && !freq_lock_lost_flag &&
		!restart |=> history_accum_en)
		else $error("history not accumulating after lock");

	crystal_lock_a: assert property ( // [R11]
		next_state == ST_FREE_RUN && crystal_oscillator_input |=>
		apll_on_crystal)
		else $error("analog loop not on crystal in free-run");

	iface_sel_a: assert property ( // [R1]
		cfg_done |-> i2c_enable != spi_enable)
		else $error("interface selection not exclusive");

	sequence s_acq_lost;
		state == ST_ACQUIRE && ref_gone && !restart;
	endsequence

	acq_abort_a: assert property ( // [R13]
		s_acq_lost |=> state == ST_FREE_RUN)
		else $error("loss during acquisition did not go free-run");

	lock_entry_a: assert property ( // [R14]
		state == ST_ACQUIRE && !ref_gone && acq_done && freq_lock_det &&
		!restart |=> state == ST_LOCKED && normal_loop_bandwidth)
		else $error("acquisition did not end in lock");

	hold_exit_a: assert property ( // [R21]
		state == ST_HOLDOVER && !ref_gone && dpll_ready && !restart |=>
		state == ST_ACQUIRE)
		else $error("holdover not left for valid input");

	hold_stay_a: assert property ( // [R17]
		state == ST_HOLDOVER && ref_gone && !restart |=>
		state == ST_HOLDOVER)
		else $error("holdover left with no input");

	not_ready_a: assert property ( // [R10]
		state == ST_FREE_RUN && !dpll_ready && !restart &&
		crystal_oscillator_input |=> state == ST_FREE_RUN &&
		apll_on_crystal)
		else $error("unconfigured dpll left crystal");

	phase_track_a: assert property ( // [R15]
		!restart && next_state != ST_HOLDOVER |=>
		phase_lock_lost_flag == !$past(phase_lock_det))
		else $error("phase flag does not follow detector");

	freq_track_a: assert property ( // [R15]
		!restart && state != ST_HOLDOVER && next_state != ST_HOLDOVER |=>
		freq_lock_lost_flag == !$past(freq_lock_det))
		else $error("frequency flag does not follow detector");

	cs_role_a: assert property ( // [R2]
		cfg_done |-> csa_is_chip_select == spi_enable)
		else $error("pin role differs from interface");

	low_pwr_top_a: assert property ( // [R5]
		cfg_done && rom_page == PAGE_LOW_PWR |-> !pll_enable)
		else $error("low power page left plls on");

	hist_off_a: assert property ( // [R16]
		!history_enable |=> !history_accum_en)
		else $error("history accumulating while disabled");

	page_range_a: assert property ( // [R3]
		cfg_done |-> rom_page < PAGE_COUNT)
		else $error("page outside the nine rom pages");
endmodule

// *** tb/scd_far_model.sv ***
// Purpose: reference and lock detector model on the dpll side
// Assumes: reference presence and acquire delay are set by the bench
// Notes: detectors drop at the next edge after the reference goes away
`timescale 1ns/1ns
module scd_far_model
	import scd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bench control
	input wire logic ref_on,
	input wire logic [3:0] acq_delay,
	input wire scd_dpll_e dpll_state,
	// reference side
	output logic crystal_oscillator_input,
	output logic ref_valid,
	output logic reference_lost,
	output logic acq_done,
	output logic freq_lock_det,
	output logic phase_lock_det
);
	logic [3:0] cnt;
	logic lock;
	logic busy;
	assign crystal_oscillator_input = 1'b1;
	assign ref_valid = ref_on;
	assign reference_lost = !ref_on;
	assign freq_lock_det = lock;
	assign phase_lock_det = lock;
	assign busy = dpll_state == ST_ACQUIRE || dpll_state == ST_LOCKED;
	// acquire completes acq_delay + 1 cycles into acquisition
	always_ff @(posedge mclk) begin
		if (sys_rst || !ref_on || !busy) begin
			cnt <= 4'h0;
			acq_done <= 1'b0;
			lock <= 1'b0;
		end else if (dpll_state == ST_ACQUIRE) begin
			if (cnt == acq_delay) begin
				acq_done <= 1'b1;
				lock <= 1'b1;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench for start-up and dpll state control
// Assumes: inputs change 1 ns after the rising edge
// Notes: every wait is bounded; a timeout ends the run
`timescale 1ns/1ns
module testbench
	import scd_pkg::*;
;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic soft_rst = 1'b0;
	logic pll_soft_rst = 1'b0;
	logic interface_select_strap = 1'b0;
	logic [1:0] page_strap_low = 2'h0;
	logic [1:0] page_strap_high = 2'h0;
	logic nv_blank = 1'b0;
	logic [1:0] stored_page_select = 2'h0;
	logic overlay_enable = 1'b0;
	logic [CFG_W-1:0] nv_loop_cfg = 16'h1e2d;
	logic [CFG_W-1:0] nv_out_cfg = 16'h3c4b;
	logic dpll_configured = 1'b0;
	logic history_enable = 1'b0;
	logic history_valid = 1'b0;
	logic [FW-1:0] holdover_freq_offset = 40'h8000000001;
	logic [FW-1:0] history_word = 40'h123456789a;
	logic ref_on = 1'b0;
	logic [3:0] acq_delay = 4'h0;
	logic crystal_oscillator_input, ref_valid, reference_lost, acq_done;
	logic freq_lock_det, phase_lock_det;
	logic i2c_enable, spi_enable, csa_is_chip_select, pll_enable, cfg_done;
	logic [PAGE_W-1:0] rom_page;
	logic [CFG_W-1:0] loop_cfg, out_cfg;
	scd_dpll_e dpll_state;
	logic normal_loop_bandwidth, apll_on_crystal, holdover_use_history;
	logic [FW-1:0] holdover_freq_word;
	logic freq_lock_lost_flag, phase_lock_lost_flag, history_accum_en;
	int miscompares = 0;
	int cmp_count = 0;

	always #5 mclk = ~mclk;

	scd_top i_dut (.*);
	scd_far_model i_far (.*);

	task chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// standard page map, then rotation by the stored select
	function automatic logic [3:0] exp_page(input logic [1:0] hi,
		input logic [1:0] lo, input logic [1:0] sel);
		logic [1:0] h;
		logic [1:0] l;
		int p;
		h = (hi == 2'h3) ? 2'h2 : hi;
		l = (lo == 2'h3) ? 2'h2 : lo;
		case ({h, l})
			4'h0: p = 0;
			4'h2: p = 1;
			4'h8: p = 2;
			4'ha: p = 3;
			4'h1: p = 4;
			4'h4: p = 5;
			4'h5: p = 6;
			4'h6: p = 7;
			default: p = 8;
		endcase
		return 4'((p + int'(sel)) % 9);
	endfunction

	task start(input logic s, input logic [1:0] hi, input logic [1:0] lo,
		input logic [1:0] sel, input logic ovl, input logic bl);
		int n;
		logic [3:0] p;
		logic u;
		logic [CFG_W-1:0] el;
		logic [CFG_W-1:0] eo;
		p = exp_page(hi, lo, bl ? 2'h0 : sel);
		u = ovl && !bl;
		el = u ? nv_loop_cfg : (p == 4'h3 ? 16'h0 : {ROM_LOOP_TAG, p});
		eo = u ? nv_out_cfg : (p == 4'h3 ? 16'h0 : {ROM_OUT_TAG, p});
		sys_rst = 1'b1;
		ref_on = 1'b0;
		interface_select_strap = s;
		page_strap_high = hi;
		page_strap_low = lo;
		stored_page_select = sel;
		overlay_enable = ovl;
		nv_blank = bl;
		tick(2);
		sys_rst = 1'b0;
		tick(1);
		// late strap and field changes must be ignored
		interface_select_strap = !s;
		page_strap_high = ~hi;
		page_strap_low = ~lo;
		stored_page_select = ~sel;
		overlay_enable = !ovl;
		n = 1;
		while (cfg_done !== 1'b1 && n < 12) begin
			tick(1);
			n++;
		end
		chk(n, u ? 5 : 4);
		if (cfg_done !== 1'b1) finish_test();
		tick(1);
		chk(i2c_enable, !s);
		chk(spi_enable, s);
		chk(csa_is_chip_select, s);
		chk(rom_page, p);
		chk(pll_enable, p != 4'h3);
		chk(loop_cfg, el);
		chk(out_cfg, eo);
		chk(dpll_state, ST_FREE_RUN);
		chk(apll_on_crystal, 1'b1);
	endtask

	task wait_st(input scd_dpll_e s);
		int i;
		i = 0;
		while (dpll_state !== s && i < 40) begin
			tick(1);
			i++;
		end
		chk(dpll_state, s);
		if (dpll_state !== s) finish_test();
	endtask

	task hold_case(input logic he, input logic hv);
		logic [FW-1:0] ew;
		ew = (he && hv) ? history_word : holdover_freq_offset;
		start(1'b0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		history_enable = he;
		history_valid = hv;
		acq_delay = 4'h6;
		ref_on = 1'b1;
		wait_st(ST_ACQUIRE);
		chk(normal_loop_bandwidth, 1'b0);
		wait_st(ST_LOCKED);
		chk(normal_loop_bandwidth, 1'b1);
		tick(2);
		chk(freq_lock_lost_flag, 1'b0);
		chk(phase_lock_lost_flag, 1'b0);
		chk(history_accum_en, he);
		ref_on = 1'b0;
		if (he && !hv) begin
			wait_st(ST_FREE_RUN);
		end else begin
			wait_st(ST_HOLDOVER);
			chk(phase_lock_lost_flag, 1'b1);
			tick(2);
			chk(freq_lock_lost_flag, 1'b0);
			chk(holdover_use_history, he && hv);
			chk(holdover_freq_word, ew);
		end
		acq_delay = 4'h0;
		ref_on = 1'b1;
		wait_st(ST_ACQUIRE);
		wait_st(ST_LOCKED);
	endtask

	task acq_loss();
		start(1'b1, 2'h1, 2'h1, 2'h0, 1'b0, 1'b0);
		acq_delay = 4'hf;
		ref_on = 1'b1;
		wait_st(ST_ACQUIRE);
		ref_on = 1'b0;
		wait_st(ST_FREE_RUN);
	endtask

	task soft_case(input logic which);
		start(1'b0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		ref_on = 1'b1;
		wait_st(ST_LOCKED);
		soft_rst = !which;
		pll_soft_rst = which;
		wait_st(ST_FREE_RUN);
		tick(4);
		chk(dpll_state, ST_FREE_RUN);
		chk(phase_lock_lost_flag, 1'b1);
		soft_rst = 1'b0;
		pll_soft_rst = 1'b0;
		wait_st(ST_ACQUIRE);
		wait_st(ST_LOCKED);
		chk(rom_page, 4'h0);
	endtask

	task low_power();
		start(1'b1, 2'h2, 2'h2, 2'h0, 1'b0, 1'b0);
		ref_on = 1'b1;
		tick(10);
		chk(dpll_state, ST_FREE_RUN);
		chk(apll_on_crystal, 1'b1);
		dpll_configured = 1'b1;
		wait_st(ST_ACQUIRE);
		wait_st(ST_LOCKED);
		dpll_configured = 1'b0;
	endtask

	initial begin
		tick(8);
		for (int i = 0; i < 9; i++) begin
			start(i[0], 2'(i / 3), 2'(i % 3), 2'h0, 1'b0, 1'b0);
		end
		start(1'b0, 2'h3, 2'h3, 2'h2, 1'b1, 1'b0);
		start(1'b1, 2'h1, 2'h0, 2'h1, 1'b1, 1'b1);
		hold_case(1'b0, 1'b0);
		hold_case(1'b1, 1'b1);
		hold_case(1'b1, 1'b0);
		acq_loss();
		soft_case(1'b0);
		soft_case(1'b1);
		low_power();
		finish_test();
	end
endmodule
